/* File: dv/cap_pin_load.sv */
`timescale 1ns/1ps
// ****************************************************************
// Pin load: counts rising edges seen on each module pin
// ****************************************************************
module cap_pin_load
   import cap_pkg::*;
(
   input  wire logic                        clk,
   input  wire logic [cap_pkg::NUM_MOD-1:0] pin,
   output int                               rise_cnt [cap_pkg::NUM_MOD]
);
   logic [NUM_MOD-1:0] prev;
   initial begin
      prev = '0;
      for (int i = 0; i < NUM_MOD; i++) begin
         rise_cnt[i] = 0;
      end
   end
   always @(posedge clk) begin
      for (int i = 0; i < NUM_MOD; i++) begin
         if (pin[i] === 1'b1 && prev[i] === 1'b0) begin
            rise_cnt[i] = rise_cnt[i] + 1;
         end
      end
      prev = pin;
   end
endmodule

/* File: dv/test_cap_top.sv */
`timescale 1ns/1ps
module test_cap_top;
   import cap_pkg::*;
   logic               clk, rst_n, run, tk, twe, mwe, lwe, hwe, wde, wdr, rpo, rpoe, wd_seen;
   logic [TMR_W-1:0]   twd, tval;
   logic [2:0]         msel, csel;
   logic [MODE_W-1:0]  mwd;
   logic [BYTE_W-1:0]  cwd;
   logic [NUM_MOD-1:0] fclr, flag, irq, pin;
   int                 rise_cnt [NUM_MOD];
   int                 error_cnt = 0;
   int                 samples_checked = 0;
   cap_top DUT (.CLK(clk), .RST_N(rst_n), .TIMER_RUN_BIT(run), .COUNT_TICK(tk),
      .TIMER_WE(twe), .TIMER_WDATA(twd), .MODE_WE(mwe), .MODE_SEL(msel), .MODE_WDATA(mwd),
      .CMP_LOW_WE(lwe), .CMP_HIGH_WE(hwe), .CMP_SEL(csel), .CMP_WDATA(cwd),
      .FLAG_CLEAR(fclr), .WATCHDOG_ENABLE_BIT(wde), .TIMER_VALUE(tval),
      .MODULE_EVENT_FLAG(flag), .MODULE_IRQ(irq), .MODULE_PIN(pin), .WD_RESET_REQ(wdr),
      .EXT_RST_PIN_O(rpo), .EXT_RST_PIN_OE(rpoe));
   cap_pin_load u_load (.clk(clk), .pin(pin), .rise_cnt(rise_cnt));
   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         wd_seen = wd_seen | wdr;
      end
   endtask
   task automatic wr_mode(input logic [2:0] m, input logic [7:0] v);
      msel = m;
      mwd = v;
      mwe = 1'b1;
      step(1);
      mwe = 1'b0;
      step(1);
   endtask
   task automatic wr_cmp(input logic [2:0] m, input logic [15:0] v);
      csel = m;
      cwd = v[7:0];
      lwe = 1'b1;
      step(1);
      lwe = 1'b0;
      cwd = v[15:8];
      hwe = 1'b1;
      step(1);
      hwe = 1'b0;
   endtask
   task automatic ld(input logic [15:0] v);
      twd = v;
      twe = 1'b1;
      step(1);
      twe = 1'b0;
   endtask
   task automatic tick(input int n);
      tk = 1'b1;
      step(n);
      tk = 1'b0;
      step(3);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_timer;
      wr_mode(3'h0, 8'h49);
      wr_mode(3'h1, 8'h48);
      wr_mode(3'h2, 8'h48);
      wr_cmp(3'h0, 16'h0005);
      wr_cmp(3'h1, 16'h0005);
      wr_cmp(3'h2, 16'h0105);
      ld(16'h0002);
      tick(4);
      chk("flag", 16'(flag), 16'h0003);
      chk("irq", 16'(irq), 16'h0001);
      step(5);
      chk("flag held", 16'(flag), 16'h0003);
      fclr = 5'h03;
      step(1);
      fclr = 5'h00;
      step(3);
      chk("flag clr", 16'(flag), 16'h0000);
      chk("irq clr", 16'(irq), 16'h0000);
      ld(16'h0103);
      tick(4);
      chk("flag hi", 16'(flag), 16'h0004);
      fclr = 5'h04;
      step(1);
      fclr = 5'h00;
   endtask
   task automatic t_run;
      run = 1'b0;
      ld(16'h1234);
      tick(3);
      chk("timer stop", tval, 16'h1234);
      run = 1'b1;
      tick(2);
      chk("timer run", tval, 16'h1236);
   endtask
   task automatic t_hso;
      wr_mode(3'h3, 8'h4c);
      wr_cmp(3'h3, 16'h0010);
      ld(16'h000e);
      tick(4);
      chk("hso pin", 16'(pin[3]), 16'h0001);
      ld(16'h000e);
      tick(4);
      chk("hso pin2", 16'(pin[3]), 16'h0000);
      chk("hso rises", 16'(rise_cnt[3]), 16'h0001);
   endtask
   task automatic t_pwm;
      wr_cmp(3'h0, 16'h4080);
      wr_cmp(3'h1, 16'h4020);
      wr_mode(3'h0, 8'h42);
      wr_mode(3'h1, 8'h42);
      ld(16'h0010);
      tick(1);
      chk("pwm low", 16'(pin[1:0]), 16'h0000);
      ld(16'h0050);
      tick(1);
      chk("pwm duty", 16'(pin[1:0]), 16'h0002);
      ld(16'h00ff);
      tick(1);
      ld(16'h003f);
      tick(1);
      chk("pwm reload", 16'(pin[1:0]), 16'h0003);
   endtask
   task automatic t_wd;
      wr_mode(3'h4, 8'h48);
      wr_cmp(3'h4, 16'h0020);
      wde = 1'b1;
      ld(16'h001e);
      wd_seen = 1'b0;
      tick(4);
      chk("wd req", 16'(wd_seen), 16'h0001);
      chk("rst pin oe", 16'({rpo, rpoe}), 16'h0000);
      wde = 1'b0;
      fclr = 5'h10;
      step(1);
      fclr = 5'h00;
      ld(16'h001e);
      wd_seen = 1'b0;
      tick(4);
      chk("wd off", 16'(wd_seen), 16'h0000);
      chk("mod4 flag", 16'(flag[4]), 16'h0001);
   endtask
   task automatic t_wd_hold;
      wr_cmp(3'h4, 16'h0030);
      wde = 1'b1;
      ld(16'h0028);
      wd_seen = 1'b0;
      tick(4);
      wr_cmp(3'h4, 16'h0040);
      tick(4);
      ld(16'h0020);
      tick(4);
      wde = 1'b0;
      ld(16'h003e);
      tick(4);
      wde = 1'b1;
      chk("wd held off", 16'(wd_seen), 16'h0000);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ****************************************************************
   // Clock, reset, sequence, watchdog
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #100000;
      error_cnt++;
      end_sim();
   end
   initial begin
      {rst_n, tk, twe, mwe, lwe, hwe, wde, wd_seen} = '0;
      run = 1'b1;
      {twd, msel, csel, mwd, cwd, fclr} = '0;
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      step(1);
      chk("reset outs", 16'({flag, irq, pin}), 16'h0000);
      t_timer();
      t_run();
      t_hso();
      t_pwm();
      t_wd();
      t_wd_hold();
      end_sim();
   end
endmodule

/* File: rtl/cap_cmp_mem.sv */
`timescale 1ns/1ps
// ****************************************************************
// Compare byte storage, registered read data
// ****************************************************************
module cap_cmp_mem
   import cap_pkg::*;
#(
   parameter int unsigned DEPTH = 5,
   parameter int unsigned AW    = 3
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              we,
   input  wire logic [AW-1:0]     waddr,
   input  wire logic [BYTE_W-1:0] wdata,
   output logic [DEPTH*BYTE_W-1:0] rdata
);
   logic [BYTE_W-1:0] mem_q [DEPTH];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= CMP_RST;
         end
      end else if (we && (32'(waddr) < DEPTH)) begin
         mem_q[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata <= '0;
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            rdata[i*BYTE_W +: BYTE_W] <= (we && 32'(waddr) == i) ? wdata : mem_q[i];
         end
      end
   end
endmodule

/* File: rtl/cap_pkg.sv */
package cap_pkg;
   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int unsigned NUM_MOD    = 5;
   localparam int unsigned WD_MOD     = 4;
   localparam int unsigned TMR_W      = 16;
   localparam int unsigned BYTE_W     = 8;
   // ****************************************************************
   // Mode register fields
   // ****************************************************************
   localparam int unsigned MODE_W     = 8;
   localparam int unsigned BIT_ECCF   = 0;
   localparam int unsigned BIT_PWM    = 1;
   localparam int unsigned BIT_TOG    = 2;
   localparam int unsigned BIT_MAT    = 3;
   localparam int unsigned BIT_COMPARATOR_ENABLE   = 6;
   // ****************************************************************
   // Reset values and low byte wrap value
   // ****************************************************************
   localparam logic [TMR_W-1:0]  TMR_RST    = 16'h0000;
   localparam logic [BYTE_W-1:0] CMP_RST    = 8'h00;
   localparam logic [BYTE_W-1:0] LOW_MAX    = 8'hff;
   localparam logic              PIN_RST    = 1'b0;
   // ****************************************************************
   // Types
   // ****************************************************************
   typedef logic [NUM_MOD-1:0] cap_mask_t;
endpackage

/* File: rtl/cap_top.sv */
`timescale 1ns/1ps
// Function
// - Irq when flag and irq enable set
// - Comparator plus match sets flag on equality
// - High-speed output toggles pin on match
// - Shared timer frequency, per-module duty byte
// - Pin low below duty byte, else high
// - Low byte wrap reloads duty from high
// - Watchdog only on module four
// - Watchdog match raises internal reset
// - Watchdog never drives external reset pin
// - Watchdog enable bit gates watchdog
// - Hardware sets flag, software clears
// - Timer counts only while run bit set
module cap_top
   import cap_pkg::*;
(
   input  wire logic                        CLK,
   input  wire logic                        RST_N,
   input  wire logic                        TIMER_RUN_BIT,
   input  wire logic                        COUNT_TICK,
   input  wire logic                        TIMER_WE,
   input  wire logic [cap_pkg::TMR_W-1:0]   TIMER_WDATA,
   input  wire logic                        MODE_WE,
   input  wire logic [2:0]                  MODE_SEL,
   input  wire logic [cap_pkg::MODE_W-1:0]  MODE_WDATA,
   input  wire logic                        CMP_LOW_WE,
   input  wire logic                        CMP_HIGH_WE,
   input  wire logic [2:0]                  CMP_SEL,
   input  wire logic [cap_pkg::BYTE_W-1:0]  CMP_WDATA,
   input  wire logic [cap_pkg::NUM_MOD-1:0] FLAG_CLEAR,
   input  wire logic                        WATCHDOG_ENABLE_BIT,
   output logic [cap_pkg::TMR_W-1:0]        TIMER_VALUE,
   output logic [cap_pkg::NUM_MOD-1:0]      MODULE_EVENT_FLAG,
   output logic [cap_pkg::NUM_MOD-1:0]      MODULE_IRQ,
   output logic [cap_pkg::NUM_MOD-1:0]      MODULE_PIN,
   output logic                             WD_RESET_REQ,
   output logic                             EXT_RST_PIN_O,
   output logic                             EXT_RST_PIN_OE
);
   import cap_pkg::*;

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [TMR_W-1:0]          timer_q;
   logic [MODE_W-1:0]         mode_q [NUM_MOD];
   logic [NUM_MOD*BYTE_W-1:0] high_rd;
   logic [BYTE_W-1:0]         low_q [NUM_MOD];
   cap_mask_t                 flag_q;
   cap_mask_t                 match_d;
   cap_mask_t                 pwm_d;
   logic                      tick;
   logic                      wrap;

   cap_cmp_mem #(
      .DEPTH (NUM_MOD),
      .AW    (3)
   ) u_high (
      .clk   (CLK),
      .rst_n (RST_N),
      .we    (CMP_HIGH_WE),
      .waddr (CMP_SEL),
      .wdata (CMP_WDATA),
      .rdata (high_rd)
   );

   function automatic logic bit_of(input logic [MODE_W-1:0] m, input int unsigned b);
      bit_of = m[b];
   endfunction

   // ****************************************************************
   // Shared timer
   // ****************************************************************
   // A load wins over the count, so no match is taken on a skipped value
   assign tick = TIMER_RUN_BIT && COUNT_TICK && !TIMER_WE;
   assign wrap = tick && (timer_q[BYTE_W-1:0] == LOW_MAX);

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         timer_q <= TMR_RST;
      end else if (TIMER_WE) begin
         timer_q <= TIMER_WDATA;
      end else if (tick) begin
         timer_q <= timer_q + 16'h0001;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         TIMER_VALUE <= TMR_RST;
      end else if (TIMER_WE) begin
         TIMER_VALUE <= TIMER_WDATA;
      end else if (tick) begin
         TIMER_VALUE <= timer_q + 16'h0001;
      end
   end

   // ****************************************************************
   // Per-module logic
   // ****************************************************************
   for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
      logic [BYTE_W-1:0] high_b;
      logic              comparator_enable;
      logic              pwm;
      logic [BYTE_W-1:0] low_d;
      assign high_b = high_rd[g*BYTE_W +: BYTE_W];
      assign comparator_enable   = bit_of(mode_q[g], BIT_COMPARATOR_ENABLE);
      assign pwm    = bit_of(mode_q[g], BIT_PWM);
      // Match evaluated once per increment on new timer value
      assign match_d[g] = tick && comparator_enable && !pwm &&
                          ({high_b, low_q[g]} == (timer_q + 16'h0001));
      // Next duty byte; the pin compares against it so a reload is glitch free
      always_comb begin
         low_d = low_q[g];
         if (CMP_LOW_WE && 32'(CMP_SEL) == g) begin
            low_d = CMP_WDATA;
         end else if (wrap && comparator_enable && pwm) begin
            low_d = high_b;
         end
      end
      assign pwm_d[g] = ((timer_q[BYTE_W-1:0] + 8'h01) >= low_d);

      always_ff @(posedge CLK) begin
         if (!RST_N) begin
            mode_q[g] <= '0;
         end else if (MODE_WE && 32'(MODE_SEL) == g) begin
            mode_q[g] <= MODE_WDATA;
         end
      end

      always_ff @(posedge CLK) begin
         if (!RST_N) begin
            low_q[g] <= CMP_RST;
         end else begin
            low_q[g] <= low_d;
         end
      end

      always_ff @(posedge CLK) begin
         if (!RST_N) begin
            flag_q[g] <= 1'b0;
         end else if (match_d[g] && bit_of(mode_q[g], BIT_MAT)) begin
            flag_q[g] <= 1'b1;
         end else if (FLAG_CLEAR[g]) begin
            flag_q[g] <= 1'b0;
         end
      end

      always_ff @(posedge CLK) begin
         if (!RST_N) begin
            MODULE_PIN[g] <= PIN_RST;
         end else if (comparator_enable && pwm) begin
            if (tick) begin
               MODULE_PIN[g] <= pwm_d[g];
            end
         end else if (match_d[g] && bit_of(mode_q[g], BIT_TOG)) begin
            MODULE_PIN[g] <= ~MODULE_PIN[g];
         end
      end
   end

   // ****************************************************************
   // Flag and interrupt outputs
   // ****************************************************************
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         MODULE_EVENT_FLAG <= '0;
         MODULE_IRQ        <= '0;
      end else begin
         for (int i = 0; i < NUM_MOD; i++) begin
            MODULE_EVENT_FLAG[i] <= flag_q[i];
            MODULE_IRQ[i] <= flag_q[i] && bit_of(mode_q[i], BIT_ECCF);
         end
      end
   end

   // ****************************************************************
   // Watchdog
   // ****************************************************************
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         WD_RESET_REQ <= 1'b0;
      end else begin
         WD_RESET_REQ <= WATCHDOG_ENABLE_BIT && match_d[WD_MOD] &&
                         bit_of(mode_q[WD_MOD], BIT_MAT);
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         EXT_RST_PIN_O  <= 1'b0;
         EXT_RST_PIN_OE <= 1'b0;
      end else begin
         EXT_RST_PIN_O  <= 1'b0;
         EXT_RST_PIN_OE <= 1'b0;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_irq;
      @(posedge CLK) disable iff (!RST_N)
      MODULE_IRQ[0] |-> $past(flag_q[0]) && $past(mode_q[0][BIT_ECCF]);
   endproperty
   a_irq: assert property (p_irq) else $error("irq without flag and enable");

   property p_flag_set;
      @(posedge CLK) disable iff (!RST_N)
      (match_d[1] && mode_q[1][BIT_MAT]) |=> flag_q[1];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set on match");

   property p_flag_hold;
      @(posedge CLK) disable iff (!RST_N)
      (flag_q[2] && !FLAG_CLEAR[2]) |=> flag_q[2];
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear");

   property p_toggle;
      @(posedge CLK) disable iff (!RST_N)
      (match_d[3] && mode_q[3][BIT_TOG] && !mode_q[3][BIT_PWM])
         |=> MODULE_PIN[3] != $past(MODULE_PIN[3]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("pin did not toggle");

   property p_stop;
      @(posedge CLK) disable iff (!RST_N)
      (!TIMER_RUN_BIT && !TIMER_WE) |=> timer_q == $past(timer_q);
   endproperty
   a_stop: assert property (p_stop) else $error("timer moved while stopped");

   property p_reload;
      @(posedge CLK) disable iff (!RST_N)
      (wrap && mode_q[0][BIT_PWM] && mode_q[0][BIT_COMPARATOR_ENABLE] && !CMP_LOW_WE)
         |=> low_q[0] == $past(high_rd[BYTE_W-1:0]);
   endproperty
   a_reload: assert property (p_reload) else $error("duty not reloaded");

   property p_pwm_lvl;
      @(posedge CLK) disable iff (!RST_N)
      (tick && mode_q[1][BIT_PWM] && mode_q[1][BIT_COMPARATOR_ENABLE])
         |=> MODULE_PIN[1] == (timer_q[BYTE_W-1:0] >= low_q[1]);
   endproperty
   a_pwm_lvl: assert property (p_pwm_lvl) else $error("pwm level wrong");

   property p_wd;
      @(posedge CLK) disable iff (!RST_N)
      WD_RESET_REQ |-> $past(WATCHDOG_ENABLE_BIT) && $past(match_d[WD_MOD]);
   endproperty
   a_wd: assert property (p_wd) else $error("watchdog reset without cause");

   property p_extpin;
      @(posedge CLK) disable iff (!RST_N)
      WD_RESET_REQ |-> !(EXT_RST_PIN_OE && EXT_RST_PIN_O);
   endproperty
   a_extpin: assert property (p_extpin) else $error("external reset driven");
endmodule
